// [word_move_defs.vh]
`ifndef WORD_MOVE_DEFS_VH
`define WORD_MOVE_DEFS_VH

// Operation codes presented on op_i.
`define OP_WORD_SWAP    3'h0
`define OP_OFFSET_STORE 3'h1
`define OP_OFFSET_LOAD  3'h2
`define OP_BIT_COPY     3'h3
`define OP_NIBBLE_COPY  3'h4

// Word and address widths of the data memory area.
`define WORD_W          16
`define ADDR_W          10
`define MEM_DEPTH       1024

// Number of words that exist in the data memory area; addresses at or
// above this boundary are non-existent.
`define DM_WORDS        14'h03E8

// Reset values of the result flags.
`define ERROR_RST       1'h0
`define ZERO_RST        1'h0

// Digit selector field positions for the nibble copy.
`define DSEL_SRC_LSB    0
`define DSEL_CNT_LSB    4
`define DSEL_DST_LSB    8

`endif

// [word_store.v]
`timescale 1ns/1ps
`include "word_move_defs.vh"

// Single-port word memory with a registered read port.
module word_store (
  // Clock.
  input  wire                 ref_clk_i,
  // Access port.
  input  wire                 we_i,
  input  wire [`ADDR_W-1:0]   addr_i,
  input  wire [`WORD_W-1:0]   wdata_i,
  output reg  [`WORD_W-1:0]   rdata_o
);

  reg [`WORD_W-1:0] mem_r [0:`MEM_DEPTH-1];  // Storage words, not reset.

  // Write-first is not needed: the unit never reads a word in the cycle it writes it.
  always @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
    rdata_o <= mem_r[addr_i];
  end

endmodule // word_store

// [word_move_exchange_unit.v]
// Operation
// RL1: False condition: skip, nothing changes.
// RL2: Swap exchanges two words' old contents.
// RL3: Indirect pointer not BCD raises error.
// RL4: Indirect address beyond area raises error.
// RL5: Store source to base plus offset.
// RL6: Store: bad offset or range errors, no write.
// RL7: Store sets zero flag from source.
// RL8: Load word at base plus offset.
// RL9: Load: bad offset or range errors, no write.
// RL10: Copy selected source bit to destination bit.
// RL11: Bit selector halves must be BCD 0..15.
// RL12: Copy one to four consecutive digits.
// RL13: Digit indices wrap to digit zero.
// RL14: Low three selector digits must be 0..3.
// RL15: Selector: source start, count-1, destination start.
`timescale 1ns/1ps
`include "word_move_defs.vh"

module word_move_exchange_unit (
  // Clock and reset.
  input  wire                 ref_clk_i,
  input  wire                 rst_n_i,
  // Instruction request.
  input  wire                 start_i,
  input  wire                 cond_i,
  input  wire [2:0]           op_i,
  input  wire [`ADDR_W-1:0]   addr_a_i,
  input  wire                 ind_a_i,
  input  wire [`ADDR_W-1:0]   addr_b_i,
  input  wire                 ind_b_i,
  input  wire [`WORD_W-1:0]   sel_i,
  // Host access to the data memory area while idle.
  input  wire                 host_we_i,
  input  wire [`ADDR_W-1:0]   host_addr_i,
  input  wire [`WORD_W-1:0]   host_wdata_i,
  output wire [`WORD_W-1:0]   host_rdata_o,
  // Status.
  output reg                  busy_o,
  output reg                  done_o,
  output reg                  error_flag_o,
  output reg                  zero_flag_o
);

  // One-hot states of the sequencer.
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_PTRA = 8'h02;
  localparam [7:0] S_PTRB = 8'h04;
  localparam [7:0] S_CHK  = 8'h08;
  localparam [7:0] S_RDA  = 8'h10;
  localparam [7:0] S_RDB  = 8'h20;
  localparam [7:0] S_WRA  = 8'h40;
  localparam [7:0] S_WRB  = 8'h80;

  reg  [7:0]          state_r;    // Sequencer state.
  reg                 phase_r;    // Read phase: 0 issues, 1 captures.
  reg  [2:0]          op_r;       // Latched operation.
  reg                 ind_b_r;    // Latched indirect flag of operand B.
  reg  [`WORD_W-1:0]  sel_r;      // Latched offset or selector word.
  reg  [`ADDR_W-1:0]  ea_a_r;     // Operand A address, resolved.
  reg  [`ADDR_W-1:0]  ea_b_r;     // Operand B address, resolved.
  reg  [`ADDR_W-1:0]  tgt_r;      // Base plus offset address.
  reg  [`WORD_W-1:0]  val_a_r;    // Word read for operand A.
  reg  [`WORD_W-1:0]  val_b_r;    // Word read for operand B.
  wire [`WORD_W-1:0]  rd_data;    // Registered memory read data.
  reg                 m_we;       // Memory write strobe.
  reg  [`ADDR_W-1:0]  m_addr;     // Memory address.
  reg  [`WORD_W-1:0]  m_wd;       // Memory write data.
  reg  [13:0]         base_sum;   // Base plus decoded offset.
  reg                 sel_bad;    // Selector or offset is invalid.
  reg  [`WORD_W-1:0]  wr_data;    // Final word written to operand B.
  wire [13:0]         ptr_val;    // Binary value of the fetched pointer word.

  // All four digits are decimal.
  function bcd_ok;
    input [15:0] w;
    begin
      bcd_ok = (w[15:12] <= 4'h9) && (w[11:8] <= 4'h9) &&
               (w[7:4] <= 4'h9) && (w[3:0] <= 4'h9);
    end
  endfunction

  // Binary value of a four-digit BCD word.
  function [13:0] bcd_val;
    input [15:0] w;
    begin
      bcd_val = ({10'h000, w[15:12]} * 14'h03E8) + ({10'h000, w[11:8]} * 14'h0064) +
                ({10'h000, w[7:4]} * 14'h000A) + {10'h000, w[3:0]};
    end
  endfunction

  // A pointer word names an existing word only if decimal and below the boundary.
  function ptr_ok;
    input [15:0] w;
    begin
      ptr_ok = bcd_ok(w) && (bcd_val(w) < `DM_WORDS);
    end
  endfunction

  // A two-digit bit designator half must be decimal and name bit 00 to 15.
  function half_ok;
    input [7:0] h;
    begin
      half_ok = (h[7:4] <= 4'h1) && (h[3:0] <= 4'h9) && ((h[7:4] == 4'h0) || (h[3:0] <= 4'h5));
    end
  endfunction

  // Bit number held in a valid designator half.
  function [3:0] half_val;
    input [7:0] h;
    begin
      half_val = h[4] ? (h[3:0] + 4'hA) : h[3:0];
    end
  endfunction

  // Move one bit from src into dst.
  function [15:0] bit_merge;
    input [15:0] dst;
    input [15:0] src;
    input [15:0] sel;
    reg   [15:0] res;
    begin
      res = dst;
      res[half_val(sel[15:8])] = src[half_val(sel[7:0])];  // RL10
      bit_merge = res;
    end
  endfunction

  // Move up to four digits from src into dst, each index wrapping modulo four.
  function [15:0] dig_merge;
    input [15:0] dst;
    input [15:0] src;
    input [15:0] sel;
    reg   [15:0] res;
    reg   [1:0]  si;
    reg   [1:0]  di;
    integer      i;
    begin
      res = dst;
      si  = sel[`DSEL_SRC_LSB +: 2];  // RL15
      di  = sel[`DSEL_DST_LSB +: 2];  // RL15
      for (i = 0; i < 4; i = i + 1) begin
        if (i[1:0] <= sel[`DSEL_CNT_LSB +: 2]) begin  // RL12
          res[di*4 +: 4] = src[si*4 +: 4];
        end
        si = si + 2'h1;  // RL13
        di = di + 2'h1;  // RL13
      end
      dig_merge = res;
    end
  endfunction

  // A function result cannot be sliced, so the pointer value is named here.
  assign ptr_val = bcd_val(rd_data);

  // Validity of the offset or selector word and the base plus offset sum.
  always @* begin
    base_sum = {4'h0, ((op_r == `OP_OFFSET_LOAD) ? ea_a_r : ea_b_r)} + bcd_val(sel_r);
    case (op_r)
      `OP_WORD_SWAP:    sel_bad = 1'b0;
      `OP_OFFSET_STORE: sel_bad = !bcd_ok(sel_r) || (base_sum >= `DM_WORDS);  // RL6
      `OP_OFFSET_LOAD:  sel_bad = !bcd_ok(sel_r) || (base_sum >= `DM_WORDS);  // RL9
      `OP_BIT_COPY:     sel_bad = !half_ok(sel_r[7:0]) || !half_ok(sel_r[15:8]);  // RL11
      `OP_NIBBLE_COPY:  sel_bad = (sel_r[3:0] > 4'h3) || (sel_r[7:4] > 4'h3) ||
                                  (sel_r[11:8] > 4'h3);  // RL14
      default:          sel_bad = 1'b1;
    endcase
  end

  // Word written to operand B or to the computed target.
  always @* begin
    case (op_r)
      `OP_BIT_COPY:    wr_data = bit_merge(val_b_r, val_a_r, sel_r);
      `OP_NIBBLE_COPY: wr_data = dig_merge(val_b_r, val_a_r, sel_r);
      default:         wr_data = val_a_r;  // RL2 RL5 RL8
    endcase
  end

  // Memory port steering; the host owns the port only while the unit is idle.
  always @* begin
    m_we   = 1'b0;
    m_addr = host_addr_i;
    m_wd   = host_wdata_i;
    case (state_r)
      S_IDLE: m_we = host_we_i;
      S_PTRA: m_addr = addr_a_i;
      S_PTRB: m_addr = ea_b_r;
      S_RDA:  m_addr = (op_r == `OP_OFFSET_LOAD) ? tgt_r : ea_a_r;  // RL8
      S_RDB:  m_addr = ea_b_r;
      S_WRA: begin
        m_we   = 1'b1;
        m_addr = ea_a_r;
        m_wd   = val_b_r;  // RL2
      end
      S_WRB: begin
        m_we   = 1'b1;
        m_addr = (op_r == `OP_OFFSET_STORE) ? tgt_r : ea_b_r;  // RL5
        m_wd   = wr_data;
      end
      default: m_we = 1'b0;
    endcase
  end

  // Sequencer. Pointer resolution comes first so that every check sees real addresses.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r      <= S_IDLE;
      phase_r      <= 1'b0;
      op_r         <= 3'h0;
      ind_b_r      <= 1'b0;
      sel_r        <= 16'h0000;
      ea_a_r       <= 10'h000;
      ea_b_r       <= 10'h000;
      tgt_r        <= 10'h000;
      val_a_r      <= 16'h0000;
      val_b_r      <= 16'h0000;
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
      error_flag_o <= `ERROR_RST;
      zero_flag_o  <= `ZERO_RST;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        S_IDLE: begin
          phase_r <= 1'b0;
          if (start_i) begin
            op_r    <= op_i;
            ind_b_r <= ind_b_i;
            sel_r   <= sel_i;
            ea_a_r  <= addr_a_i;
            ea_b_r  <= addr_b_i;
            if (!cond_i) begin
              // A false condition ends at once with flags and memory untouched.
              done_o <= 1'b1;  // RL1
            end else begin
              busy_o       <= 1'b1;
              error_flag_o <= 1'b0;
              state_r      <= ind_a_i ? S_PTRA : (ind_b_i ? S_PTRB : S_CHK);
            end
          end
        end
        S_PTRA, S_PTRB: begin
          phase_r <= ~phase_r;
          if (phase_r) begin
            if (!ptr_ok(rd_data)) begin
              // An indirect word that names no existing word aborts the instruction.
              error_flag_o <= 1'b1;  // RL3 RL4
              busy_o       <= 1'b0;
              done_o       <= 1'b1;
              state_r      <= S_IDLE;
            end else if (state_r == S_PTRA) begin
              ea_a_r  <= ptr_val[`ADDR_W-1:0];
              state_r <= ind_b_r ? S_PTRB : S_CHK;
            end else begin
              ea_b_r  <= ptr_val[`ADDR_W-1:0];
              state_r <= S_CHK;
            end
          end
        end
        S_CHK: begin
          tgt_r <= base_sum[`ADDR_W-1:0];
          if (sel_bad) begin
            error_flag_o <= 1'b1;  // RL6 RL9 RL11 RL14
            busy_o       <= 1'b0;
            done_o       <= 1'b1;
            state_r      <= S_IDLE;
          end else begin
            state_r <= S_RDA;
          end
        end
        S_RDA: begin
          phase_r <= ~phase_r;
          if (phase_r) begin
            val_a_r <= rd_data;
            // Store and load need only one word; the rest also read operand B.
            if ((op_r == `OP_OFFSET_STORE) || (op_r == `OP_OFFSET_LOAD)) begin
              state_r <= S_WRB;
            end else begin
              state_r <= S_RDB;
            end
          end
        end
        S_RDB: begin
          phase_r <= ~phase_r;
          if (phase_r) begin
            val_b_r <= rd_data;
            state_r <= (op_r == `OP_WORD_SWAP) ? S_WRA : S_WRB;  // RL2
          end
        end
        S_WRA: begin
          state_r <= S_WRB;
        end
        S_WRB: begin
          if ((op_r == `OP_OFFSET_STORE) || (op_r == `OP_OFFSET_LOAD)) begin
            zero_flag_o <= (val_a_r == 16'h0000);  // RL7
          end
          busy_o  <= 1'b0;
          done_o  <= 1'b1;
          state_r <= S_IDLE;
        end
        default: begin
          busy_o  <= 1'b0;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // Data memory area; its read register feeds the host read port directly.
  word_store u_store (
    .ref_clk_i (ref_clk_i),
    .we_i      (m_we),
    .addr_i    (m_addr),
    .wdata_i   (m_wd),
    .rdata_o   (rd_data)
  );

  assign host_rdata_o = rd_data;

endmodule // word_move_exchange_unit

// [word_move_asserts.sv]
`timescale 1ns/1ps
`include "word_move_defs.vh"

// Port-level timing and flag checks for the exchange unit.
module word_move_checker (
  // Clock and reset.
  input wire               ref_clk_i,
  input wire               rst_n_i,
  // Request.
  input wire               start_i,
  input wire               cond_i,
  input wire [2:0]         op_i,
  input wire               ind_a_i,
  input wire               ind_b_i,
  input wire [`WORD_W-1:0] sel_i,
  // Status.
  input wire               busy_o,
  input wire               done_o,
  input wire               error_flag_o,
  input wire               zero_flag_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Executed request with direct operands, so the latency is fixed.
  wire go = start_i && !busy_o && cond_i && !ind_a_i && !ind_b_i;

  a_busy_on_take: assert property (
    start_i && !busy_o && cond_i |=> busy_o && !done_o)
    else $error("executed request not taken");
  a_skip_untouched: assert property (
    start_i && !busy_o && !cond_i |=> done_o && $stable(error_flag_o) && $stable(zero_flag_o))
    else $error("skipped request altered state");
  a_swap_time: assert property (
    go && op_i == `OP_WORD_SWAP |-> ##8 done_o && !error_flag_o)
    else $error("swap end wrong");
  a_store_bad_ofs: assert property (
    go && op_i == `OP_OFFSET_STORE && sel_i[3:0] > 4'h9 |-> ##[2:6] done_o && error_flag_o)
    else $error("store offset fault missed");
  a_load_bad_ofs: assert property (
    go && op_i == `OP_OFFSET_LOAD && sel_i[7:4] > 4'h9 |-> ##[2:6] done_o && error_flag_o)
    else $error("load offset fault missed");
  a_bit_bad_sel: assert property (
    go && op_i == `OP_BIT_COPY && sel_i[7:0] > 8'h15 |-> ##[2:3] done_o && error_flag_o)
    else $error("bit selector fault missed");
  a_bit_good_end: assert property (
    go && op_i == `OP_BIT_COPY && sel_i[7:0] == 8'h00 && sel_i[15:8] <= 8'h15
    && sel_i[11:8] <= 4'h9 |-> ##7 done_o && !error_flag_o)
    else $error("bit copy end wrong");
  a_digit_bad_sel: assert property (
    go && op_i == `OP_NIBBLE_COPY && sel_i[7:4] > 4'h3 |-> ##[2:3] done_o && error_flag_o)
    else $error("digit selector fault missed");
  a_digit_good_end: assert property (
    go && op_i == `OP_NIBBLE_COPY && (sel_i[11:0] & 12'hCCC) == 12'h000
    |-> ##7 done_o && !error_flag_o)
    else $error("digit copy end wrong");
endmodule // word_move_checker

// [seq_model.sv]
`timescale 1ns/1ps
`include "word_move_defs.vh"

// Instruction sequencer and host loader standing in front of the unit.
module seq_model (
  // Clock and unit outputs.
  input  wire               ref_clk_i,
  input  wire               done_i,
  input  wire [`WORD_W-1:0] rdata_i,
  // Instruction request.
  output reg                start_o,
  output reg                cond_o,
  output reg  [2:0]         op_o,
  output reg  [`ADDR_W-1:0] addr_a_o,
  output reg                ind_a_o,
  output reg  [`ADDR_W-1:0] addr_b_o,
  output reg                ind_b_o,
  output reg  [`WORD_W-1:0] sel_o,
  // Host memory port.
  output reg                host_we_o,
  output reg  [`ADDR_W-1:0] host_addr_o,
  output reg  [`WORD_W-1:0] host_wdata_o
);
  // Everything idle at time zero.
  initial begin
    {start_o, cond_o, op_o, addr_a_o, ind_a_o, addr_b_o, ind_b_o, sel_o} = 43'h0;
    {host_we_o, host_addr_o, host_wdata_o} = 27'h0;
  end

  // Operands are held until done, since operand A is reread for pointers.
  task run(input c, input [2:0] op, input [9:0] a, input ia, input [9:0] b, input ib,
           input [15:0] sel);
    begin
      @(negedge ref_clk_i);
      {cond_o, op_o, addr_a_o, ind_a_o, addr_b_o, ind_b_o, sel_o} = {c, op, a, ia, b, ib, sel};
      start_o = 1'b1;
      @(negedge ref_clk_i);
      start_o = 1'b0;
      // No local limit: a missing done is left to the bench's cycle ceiling.
      while (done_i !== 1'b1) begin
        @(negedge ref_clk_i);
      end
    end
  endtask

  // One-cycle host write.
  task wr(input [9:0] ad, input [15:0] d);
    begin
      @(negedge ref_clk_i);
      {host_we_o, host_addr_o, host_wdata_o} = {1'b1, ad, d};
      @(negedge ref_clk_i);
      host_we_o = 1'b0;
    end
  endtask

  // Read data is registered, so it shows a cycle after the address.
  task rd(input [9:0] ad, output [15:0] d);
    begin
      @(negedge ref_clk_i);
      host_addr_o = ad;
      @(negedge ref_clk_i);
      d = rdata_i;
    end
  endtask
endmodule // seq_model

// [tb_top.sv]
`timescale 1ns/1ps
`include "word_move_defs.vh"

module tb_top;
  reg ref_clk_i;
  reg rst_n_i;
  wire start_i, cond_i, ind_a_i, ind_b_i, host_we_i, busy_o, done_o, error_flag_o, zero_flag_o;
  wire [2:0] op_i;
  wire [9:0] addr_a_i, addr_b_i, host_addr_i;
  wire [15:0] sel_i, host_wdata_i, host_rdata_o;
  integer err_total, checked, cyc;

  word_move_exchange_unit uut (.ref_clk_i, .rst_n_i, .start_i, .cond_i, .op_i, .addr_a_i,
    .ind_a_i, .addr_b_i, .ind_b_i, .sel_i, .host_we_i, .host_addr_i, .host_wdata_i,
    .host_rdata_o, .busy_o, .done_o, .error_flag_o, .zero_flag_o);
  seq_model seq (.ref_clk_i, .done_i(done_o), .rdata_i(host_rdata_o), .start_o(start_i),
    .cond_o(cond_i), .op_o(op_i), .addr_a_o(addr_a_i), .ind_a_o(ind_a_i), .addr_b_o(addr_b_i),
    .ind_b_o(ind_b_i), .sel_o(sel_i), .host_we_o(host_we_i), .host_addr_o(host_addr_i),
    .host_wdata_o(host_wdata_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  task final_report;
    begin
      if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // The run needs well under a thousand cycles; a hang ends it here.
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      err_total = err_total + 1;
      final_report;
    end
  end

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task mchk(input [9:0] ad, input [15:0] exp);
    reg [15:0] d;
    begin
      seq.rd(ad, d);
      chk(d, exp);
    end
  endtask
  task fchk(input e, input z);
    chk({14'h0000, error_flag_o, zero_flag_o}, {14'h0000, e, z});
  endtask
  // Executed request with direct operands.
  task go(input [2:0] op, input [9:0] a, input [9:0] b, input [15:0] sel);
    seq.run(1'b1, op, a, 1'b0, b, 1'b0, sel);
  endtask

  task t_swap;
    begin
      seq.wr(10'h00A, 16'h1234);
      seq.wr(10'h00B, 16'h5678);
      seq.wr(10'h028, 16'h0010);
      seq.wr(10'h029, 16'h00A0);
      seq.wr(10'h02A, 16'h1000);
      go(`OP_WORD_SWAP, 10'h00A, 10'h00B, 16'h0000);
      mchk(10'h00A, 16'h5678);
      mchk(10'h00B, 16'h1234);
      seq.run(1'b1, `OP_WORD_SWAP, 10'h028, 1'b1, 10'h00B, 1'b0, 16'h0000);
      mchk(10'h00A, 16'h1234);
      seq.run(1'b1, `OP_WORD_SWAP, 10'h00B, 1'b0, 10'h028, 1'b1, 16'h0000);
      mchk(10'h00B, 16'h1234);
      seq.run(1'b1, `OP_WORD_SWAP, 10'h029, 1'b1, 10'h00B, 1'b0, 16'h0000);
      fchk(1'b1, 1'b0);
      seq.run(1'b1, `OP_WORD_SWAP, 10'h02A, 1'b1, 10'h00B, 1'b0, 16'h0000);
      fchk(1'b1, 1'b0);
      seq.run(1'b0, `OP_WORD_SWAP, 10'h00A, 1'b0, 10'h00B, 1'b0, 16'h0000);
      fchk(1'b1, 1'b0);
      mchk(10'h00B, 16'h1234);
    end
  endtask

  task t_store_load;
    begin
      seq.wr(10'h014, 16'h0000);
      seq.wr(10'h015, 16'hABCD);
      seq.wr(10'h3E8, 16'h5A5A);
      seq.wr(10'h0CD, 16'h4321);
      go(`OP_OFFSET_STORE, 10'h014, 10'h064, 16'h0025);
      fchk(1'b0, 1'b1);
      mchk(10'h07D, 16'h0000);
      go(`OP_OFFSET_STORE, 10'h015, 10'h064, 16'h0026);
      fchk(1'b0, 1'b0);
      mchk(10'h07E, 16'hABCD);
      go(`OP_OFFSET_STORE, 10'h015, 10'h3DE, 16'h0010);
      mchk(10'h3E8, 16'h5A5A);
      // A bad offset that would still land on a known zero word if used.
      go(`OP_OFFSET_STORE, 10'h015, 10'h064, 16'h001F);
      fchk(1'b1, 1'b0);
      mchk(10'h07D, 16'h0000);
      go(`OP_OFFSET_LOAD, 10'h0C8, 10'h01E, 16'h0005);
      mchk(10'h01E, 16'h4321);
      go(`OP_OFFSET_LOAD, 10'h3E7, 10'h01E, 16'h0001);
      fchk(1'b1, 1'b0);
      go(`OP_OFFSET_LOAD, 10'h0C8, 10'h01E, 16'h00C0);
      mchk(10'h01E, 16'h4321);
    end
  endtask

  task t_bits;
    begin
      seq.wr(10'h032, 16'h0001);
      seq.wr(10'h033, 16'h0000);
      seq.wr(10'h03C, 16'h4321);
      go(`OP_BIT_COPY, 10'h032, 10'h033, 16'h1500);
      mchk(10'h033, 16'h8000);
      go(`OP_BIT_COPY, 10'h032, 10'h033, 16'h0016);
      fchk(1'b1, 1'b0);
      go(`OP_NIBBLE_COPY, 10'h03C, 10'h03D, 16'h0233);
      fchk(1'b0, 1'b0);
      mchk(10'h03D, 16'h1432);
      go(`OP_NIBBLE_COPY, 10'h03C, 10'h03D, 16'h0040);
      fchk(1'b1, 1'b0);
      mchk(10'h03D, 16'h1432);
    end
  endtask

  initial begin
    err_total = 0;
    checked = 0;
    cyc = 0;
    rst_n_i = 1'b0;
    repeat (12) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_swap;
    t_store_load;
    t_bits;
    final_report;
  end
endmodule // tb_top

bind word_move_exchange_unit word_move_checker chk_u (.ref_clk_i, .rst_n_i, .start_i, .cond_i,
  .op_i, .ind_a_i, .ind_b_i, .sel_i, .busy_o, .done_o, .error_flag_o, .zero_flag_o);
